// ===== core/sci_flags_pkg.sv
/*
  Constants for the serial status-flag block: register offsets,
  field positions and reset values.
  Assumes a 32-bit Wishbone register bus with byte addresses.
*/
package sci_flags_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_STAT1 = 8'h04;
  localparam logic [7:0] OFS_CTRL1 = 8'h08;
  localparam logic [7:0] OFS_CTRL3 = 8'h0c;
  localparam logic [7:0] OFS_EVT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  // ----------------------------------------------------------------
  // Status one fields
  // ----------------------------------------------------------------
  localparam int S1_TX_EMPTY = 7;
  localparam int S1_TX_DONE = 6;
  localparam int S1_RX_FULL = 5;
  localparam int S1_IDLE = 4;
  localparam int S1_OVR = 3;
  localparam int S1_NOISE = 2;
  localparam int S1_FRAME = 1;
  localparam int S1_PARITY = 0;
  // ----------------------------------------------------------------
  // Control one and control three fields
  // ----------------------------------------------------------------
  localparam int C1_EMPTY_IE = 7;
  localparam int C1_DONE_IE = 6;
  localparam int C1_NINE = 4;
  localparam int C3_RX_NINTH = 7;
  localparam int C3_TX_NINTH = 6;
  // ----------------------------------------------------------------
  // Event status bits and reset values
  // ----------------------------------------------------------------
  localparam int EVT_W = 4;
  localparam int EV_RXFULL = 0;
  localparam int EV_IDLE = 1;
  localparam int EV_OVR = 2;
  localparam int EV_ERR = 3;
  localparam logic [EVT_W-1:0] EVT_RST = 4'h0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [8:0] WORD_ZERO = 9'h000;
  localparam logic [31:0] DAT_ZERO = 32'h0000_0000;
endpackage : sci_flags_pkg

// ===== core/sci_w1c_status.sv
/*
  Sticky status bits: hardware sets, software clears by writing one.
  Assumes set and clear are one-cycle strobes on sys_clk.
*/
`timescale 1ns/100ps
module sci_w1c_status #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Set and clear strobes
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // Status
  output logic [W-1:0] stat_q
);
  // ----------------------------------------------------------------
  // Sticky bits, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr) | set;
    end
  end

  a_set_wins: assert property (@(posedge sys_clk) disable iff (srst)
    (set != '0) |=> ((stat_q & $past(set)) == $past(set)))
    else $error("set bit lost");
endmodule : sci_w1c_status

// ===== core/sci_read_seq_flag.sv
/*
  A flag cleared by a read of status one while it is set, then a read
  of the data register, and optionally a read of control three.
  Assumes read strobes last one cycle, one per bus access.
*/
`timescale 1ns/100ps
module sci_read_seq_flag #(
  parameter bit RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Hardware set
  input wire logic set,
  // Read strobes
  input wire logic status_rd,
  input wire logic data_rd,
  input wire logic extra_rd,
  input wire logic need_extra,
  // Flag
  output logic flag_q
);
  logic armed_q;
  logic data_seen_q;
  logic extra_seen_q;
  logic done;

  assign done = armed_q && (data_seen_q || data_rd) &&
    (!need_extra || extra_seen_q || extra_rd);

  // ----------------------------------------------------------------
  // Flag
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flag_q <= RST_VAL;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (done) begin
      flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Arming by a status read that saw the flag set
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst || set || done) begin
      armed_q <= 1'b0;
    end else if (status_rd && flag_q) begin
      armed_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Reads seen after arming, in either order
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst || set || done || !armed_q) begin
      data_seen_q <= 1'b0;
      extra_seen_q <= 1'b0;
    end else begin
      data_seen_q <= data_seen_q || data_rd;
      extra_seen_q <= extra_seen_q || extra_rd;
    end
  end

  sequence s_arm_hit;
    status_rd && flag_q && !set;
  endsequence
  sequence s_data_only;
    data_rd && !set;
  endsequence

  a_plain_clear: assert property (@(posedge sys_clk) disable iff (srst)
    ((!need_extra && !set) throughout (s_arm_hit ##[3:8] s_data_only))
    |=> !flag_q)
    else $error("flag not cleared by status then data read");
  a_need_ninth: assert property (@(posedge sys_clk) disable iff (srst)
    (armed_q && need_extra && !extra_seen_q && !extra_rd && flag_q)
    |=> flag_q)
    else $error("flag cleared without control three read");
  a_clear_armed: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(flag_q) |-> $past(armed_q))
    else $error("flag cleared without armed status read");
endmodule : sci_read_seq_flag

// ===== core/sci_status_flags_ninebit.sv
/*
  Status flags and 9-bit data handling of an asynchronous serial
  interface, reached over classic Wishbone.
  Assumes external shifters: the receiver offers one character per
  pulse with its error bits, the transmitter takes a word when ready.
*/
// Our own choices: the placing of the registers and the Wishbone slave port.
// How it works
// - Complete enable set: interrupt while complete flag set
// - Enables clear: no interrupt, flags still readable; the code still interrupts on event bits that are set in the mask register
// - Full flag clears: status read, then data
// - 9-bit mode also needs control three read
// - Idle flag clears: status read, then data
// - Idle stays clear until new character received
// - Error flags set together with full flag
// - No error flags for overrun-discarded characters
// - Full when new character: overrun, discard it
// - Word-length bit makes both directions 9-bit
// - Ninth bit above data MSB in control three
// - Ninth transmit bit copied with data load
// - Ninth transmit bit kept across characters
// - Ninth-bit and data reads in either order
`timescale 1ns/100ps
module sci_status_flags_ninebit (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receive shifter side
  input wire logic rx_char_valid,
  input wire logic [8:0] rx_char,
  input wire logic rx_noise,
  input wire logic rx_framing,
  input wire logic rx_parity,
  input wire logic rx_idle_seen,
  // Transmit shifter side
  input wire logic tx_shifter_ready,
  input wire logic tx_shifter_done,
  output logic tx_load_q,
  output logic [8:0] tx_word_q,
  output logic nine_bit_mode_q,
  // Interrupt
  output logic irq_q
);
  logic go, rd_go, wr_go, rd_data, rd_stat, rd_c3;
  logic wr_data, wr_c1, wr_c3, wr_evt, wr_mask;
  logic accept, overrun, idle_set, load;
  logic rx_full;
  logic idle_flag;
  logic or_flag;
  logic noise_flag;
  logic framing_error_flag;
  logic parity_error_flag;
  logic [7:0] status_one;
  logic [7:0] rx_data_q;
  logic ninth_receive_bit_q;
  logic [7:0] tx_buf_q;
  logic ninth_transmit_bit_q;
  logic transmit_buffer_empty_flag_q;
  logic transmit_complete_flag_q;
  logic transmit_buffer_irq_enable_q;
  logic transmit_complete_irq_enable_q;
  logic idle_armed_q;
  logic [sci_flags_pkg::EVT_W-1:0] evt_set;
  logic [sci_flags_pkg::EVT_W-1:0] evt_clr;
  logic [sci_flags_pkg::EVT_W-1:0] evt_q;
  logic [sci_flags_pkg::EVT_W-1:0] mask_q;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // Bus decode: one access taken per request, ack next cycle
  // ----------------------------------------------------------------
  assign go = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_go = go && !wb_we_i;
  assign wr_go = go && wb_we_i && wb_sel_i[0];
  assign rd_data = rd_go && (wb_adr_i == sci_flags_pkg::OFS_DATA);
  assign rd_stat = rd_go && (wb_adr_i == sci_flags_pkg::OFS_STAT1);
  assign rd_c3 = rd_go && (wb_adr_i == sci_flags_pkg::OFS_CTRL3);
  assign wr_data = wr_go && (wb_adr_i == sci_flags_pkg::OFS_DATA);
  assign wr_c1 = wr_go && (wb_adr_i == sci_flags_pkg::OFS_CTRL1);
  assign wr_c3 = wr_go && (wb_adr_i == sci_flags_pkg::OFS_CTRL3);
  assign wr_evt = wr_go && (wb_adr_i == sci_flags_pkg::OFS_EVT);
  assign wr_mask = wr_go && (wb_adr_i == sci_flags_pkg::OFS_MASK);

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  assign overrun = rx_char_valid && rx_full;
  assign accept = rx_char_valid && !rx_full;
  assign idle_set = rx_idle_seen && idle_armed_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_data_q <= sci_flags_pkg::BYTE_ZERO;
      ninth_receive_bit_q <= 1'b0;
    end else if (accept) begin
      rx_data_q <= rx_char[7:0];
      ninth_receive_bit_q <= nine_bit_mode_q && rx_char[8];
    end
  end

  // Idle may set once, then waits for a received character
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      idle_armed_q <= 1'b1;
    end else if (accept) begin
      idle_armed_q <= 1'b1;
    end else if (idle_set) begin
      idle_armed_q <= 1'b0;
    end
  end

  sci_read_seq_flag #(.RST_VAL(1'b0)) u_rx_full (
    .sys_clk(sys_clk), .srst(srst), .set(accept),
    .status_rd(rd_stat), .data_rd(rd_data), .extra_rd(rd_c3),
    .need_extra(nine_bit_mode_q),
    .flag_q(rx_full)
  );
  sci_read_seq_flag #(.RST_VAL(1'b0)) u_idle (
    .sys_clk(sys_clk), .srst(srst), .set(idle_set),
    .status_rd(rd_stat), .data_rd(rd_data), .extra_rd(1'b0),
    .need_extra(1'b0),
    .flag_q(idle_flag)
  );
  sci_read_seq_flag #(.RST_VAL(1'b0)) u_ovr (
    .sys_clk(sys_clk), .srst(srst), .set(overrun),
    .status_rd(rd_stat), .data_rd(rd_data), .extra_rd(1'b0),
    .need_extra(1'b0),
    .flag_q(or_flag)
  );
  sci_read_seq_flag #(.RST_VAL(1'b0)) u_noise (
    .sys_clk(sys_clk), .srst(srst), .set(accept && rx_noise),
    .status_rd(rd_stat), .data_rd(rd_data), .extra_rd(1'b0),
    .need_extra(1'b0),
    .flag_q(noise_flag)
  );
  sci_read_seq_flag #(.RST_VAL(1'b0)) u_frame (
    .sys_clk(sys_clk), .srst(srst), .set(accept && rx_framing),
    .status_rd(rd_stat), .data_rd(rd_data), .extra_rd(1'b0),
    .need_extra(1'b0),
    .flag_q(framing_error_flag)
  );
  sci_read_seq_flag #(.RST_VAL(1'b0)) u_parity (
    .sys_clk(sys_clk), .srst(srst), .set(accept && rx_parity),
    .status_rd(rd_stat), .data_rd(rd_data), .extra_rd(1'b0),
    .need_extra(1'b0),
    .flag_q(parity_error_flag)
  );

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      nine_bit_mode_q <= 1'b0;
      transmit_buffer_irq_enable_q <= 1'b0;
      transmit_complete_irq_enable_q <= 1'b0;
    end else if (wr_c1) begin
      nine_bit_mode_q <= wb_dat_i[sci_flags_pkg::C1_NINE];
      transmit_buffer_irq_enable_q <= wb_dat_i[sci_flags_pkg::C1_EMPTY_IE];
      transmit_complete_irq_enable_q <= wb_dat_i[sci_flags_pkg::C1_DONE_IE];
    end
  end

  // Ninth transmit bit changes only on a control three write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ninth_transmit_bit_q <= 1'b0;
    end else if (wr_c3) begin
      ninth_transmit_bit_q <= wb_dat_i[sci_flags_pkg::C3_TX_NINTH];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mask_q <= sci_flags_pkg::EVT_RST;
    end else if (wr_mask) begin
      mask_q <= wb_dat_i[sci_flags_pkg::EVT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  assign load = !transmit_buffer_empty_flag_q && tx_shifter_ready &&
    !tx_load_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_buf_q <= sci_flags_pkg::BYTE_ZERO;
    end else if (wr_data) begin
      tx_buf_q <= wb_dat_i[7:0];
    end
  end

  // Buffer empty: a data write fills it, a shifter load empties it
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      transmit_buffer_empty_flag_q <= 1'b1;
    end else if (wr_data) begin
      transmit_buffer_empty_flag_q <= 1'b0;
    end else if (load) begin
      transmit_buffer_empty_flag_q <= 1'b1;
    end
  end

  // Ninth bit goes to the shifter in the same load as the data
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_load_q <= 1'b0;
      tx_word_q <= sci_flags_pkg::WORD_ZERO;
    end else begin
      tx_load_q <= load;
      if (load) begin
        tx_word_q <= {nine_bit_mode_q && ninth_transmit_bit_q,
          tx_buf_q};
      end
    end
  end

  // Complete: shifter idle with nothing pending; set wins over write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      transmit_complete_flag_q <= 1'b1;
    end else if (tx_shifter_done && transmit_buffer_empty_flag_q) begin
      transmit_complete_flag_q <= 1'b1;
    end else if (wr_data) begin
      transmit_complete_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------------------------------
  assign evt_set = {accept && (rx_noise || rx_framing || rx_parity),
    overrun, idle_set, accept};
  assign evt_clr = wr_evt ? wb_dat_i[sci_flags_pkg::EVT_W-1:0] :
    sci_flags_pkg::EVT_RST;

  sci_w1c_status #(.W(sci_flags_pkg::EVT_W)) u_evt (
    .sys_clk(sys_clk), .srst(srst), .set(evt_set), .clr(evt_clr),
    .stat_q(evt_q)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (transmit_complete_irq_enable_q &&
        transmit_complete_flag_q) ||
        (transmit_buffer_irq_enable_q && transmit_buffer_empty_flag_q) ||
        ((evt_q & mask_q) != sci_flags_pkg::EVT_RST);
    end
  end

  // ----------------------------------------------------------------
  // Read data and acknowledge
  // ----------------------------------------------------------------
  assign status_one = {transmit_buffer_empty_flag_q,
    transmit_complete_flag_q, rx_full, idle_flag, or_flag, noise_flag,
    framing_error_flag, parity_error_flag};

  always_comb begin
    rd_mux = sci_flags_pkg::DAT_ZERO;
    case (wb_adr_i)
      sci_flags_pkg::OFS_DATA: rd_mux[7:0] = rx_data_q;
      sci_flags_pkg::OFS_STAT1: rd_mux[7:0] = status_one;
      sci_flags_pkg::OFS_CTRL1: begin
        rd_mux[sci_flags_pkg::C1_NINE] = nine_bit_mode_q;
        rd_mux[sci_flags_pkg::C1_EMPTY_IE] = transmit_buffer_irq_enable_q;
        rd_mux[sci_flags_pkg::C1_DONE_IE] = transmit_complete_irq_enable_q;
      end
      sci_flags_pkg::OFS_CTRL3: begin
        rd_mux[sci_flags_pkg::C3_RX_NINTH] = ninth_receive_bit_q;
        rd_mux[sci_flags_pkg::C3_TX_NINTH] = ninth_transmit_bit_q;
      end
      sci_flags_pkg::OFS_EVT: rd_mux[sci_flags_pkg::EVT_W-1:0] = evt_q;
      sci_flags_pkg::OFS_MASK: rd_mux[sci_flags_pkg::EVT_W-1:0] = mask_q;
      default: rd_mux = sci_flags_pkg::DAT_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= sci_flags_pkg::DAT_ZERO;
    end else begin
      wb_ack_o <= go;
      wb_dat_o <= rd_go ? rd_mux : sci_flags_pkg::DAT_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_tc_irq: assert property (@(posedge sys_clk) disable iff (srst)
    (transmit_complete_irq_enable_q && transmit_complete_flag_q)
    |=> irq_q)
    else $error("complete flag enabled but no interrupt");
  a_poll_quiet: assert property (@(posedge sys_clk) disable iff (srst)
    (!transmit_complete_irq_enable_q && !transmit_buffer_irq_enable_q &&
    ((evt_q & mask_q) == sci_flags_pkg::EVT_RST)) |=> !irq_q)
    else $error("interrupt with enables clear");
  a_err_with_full: assert property (@(posedge sys_clk) disable iff (srst)
    (accept && rx_framing) |=> (rx_full && framing_error_flag))
    else $error("framing flag not set with full flag");
  a_no_err_ovr: assert property (@(posedge sys_clk) disable iff (srst)
    (overrun && !noise_flag && !rd_stat) |=> !noise_flag)
    else $error("noise flag set by discarded character");
  a_overrun_keep: assert property (@(posedge sys_clk) disable iff (srst)
    overrun |=> (or_flag && $stable(rx_data_q)))
    else $error("overrun not flagged or data replaced");
  a_idle_rearm: assert property (@(posedge sys_clk) disable iff (srst)
    !idle_armed_q |=> !$rose(idle_flag))
    else $error("idle flag set again before a new character");
  a_tx_ninth: assert property (@(posedge sys_clk) disable iff (srst)
    tx_load_q |-> (tx_word_q[8] ==
    ($past(nine_bit_mode_q) && $past(ninth_transmit_bit_q))))
    else $error("ninth bit not loaded with data");
  a_t8_keep: assert property (@(posedge sys_clk) disable iff (srst)
    !wr_c3 |=> $stable(ninth_transmit_bit_q))
    else $error("ninth transmit bit changed without write");
  a_rx_ninth: assert property (@(posedge sys_clk) disable iff (srst)
    (accept && !nine_bit_mode_q) |=> !ninth_receive_bit_q)
    else $error("ninth receive bit stored in 8-bit mode");
endmodule : sci_status_flags_ninebit

// ===== tb/shifter_model.sv
/*
  Model of the receive and transmit shifters beside the flag block.
  Assumes the bench calls its tasks just after a rising sys_clk edge.
*/
`timescale 1ns/100ps
module shifter_model (
  // Clock
  input wire logic sys_clk,
  // Receive side
  output logic rx_char_valid,
  output logic [8:0] rx_char,
  output logic [2:0] rx_err,
  output logic rx_idle_seen,
  // Transmit side
  output logic tx_shifter_ready,
  output logic tx_shifter_done,
  input wire logic tx_load_q,
  input wire logic [8:0] tx_word_q
);
  logic [8:0] last_word_q;
  int loads;
  int busy;
  initial begin
    rx_char_valid = 1'b0;
    rx_char = 9'h000;
    rx_err = 3'h0;
    rx_idle_seen = 1'b0;
    tx_shifter_ready = 1'b1;
    tx_shifter_done = 1'b0;
    loads = 0;
    busy = 0;
  end
  // ----------------------------------------------------------------
  // Receiver: one character per pulse, errors {noise,framing,parity}
  // ----------------------------------------------------------------
  task automatic send_char(input logic [8:0] c, input logic [2:0] e);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    rx_err <= e;
    @(posedge sys_clk);
    rx_char_valid <= 1'b0;
    rx_char <= ~c;
    rx_err <= ~e;
  endtask : send_char
  task automatic idle_pulse;
    rx_idle_seen <= 1'b1;
    @(posedge sys_clk);
    rx_idle_seen <= 1'b0;
  endtask : idle_pulse
  // ----------------------------------------------------------------
  // Transmitter: busy a few cycles per word, then a done pulse
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    tx_shifter_done <= (tx_load_q !== 1'b1) && (busy == 1);
    if (tx_load_q === 1'b1) begin
      last_word_q <= tx_word_q;
      loads <= loads + 1;
      busy <= 4;
      tx_shifter_ready <= 1'b0;
    end else if (busy > 1) begin
      busy <= busy - 1;
    end else if (busy == 1) begin
      busy <= 0;
      tx_shifter_ready <= 1'b1;
    end
  end
endmodule : shifter_model

// ===== tb/tb.sv
/*
  Self-checking bench for the serial status-flag block.
  Assumes the shifter model in tb/ and classic Wishbone timing.
*/
`timescale 1ns/100ps
module tb;
  logic sys_clk, srst, cyc, stb, we, irq_q, nine_bit_mode_q, ack;
  logic [7:0] adr, q;
  logic [31:0] dat_i, dat_o;
  logic rx_v, idle, rdy, done, tx_load_q;
  logic [8:0] rx_c, tx_word_q;
  logic [2:0] rx_err;
  int mismatches = 0;
  int check_count = 0;
  shifter_model model (.sys_clk(sys_clk), .rx_char_valid(rx_v),
    .rx_char(rx_c), .rx_err(rx_err), .rx_idle_seen(idle),
    .tx_shifter_ready(rdy), .tx_shifter_done(done),
    .tx_load_q(tx_load_q), .tx_word_q(tx_word_q));
  sci_status_flags_ninebit dut (.sys_clk(sys_clk), .srst(srst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .rx_char_valid(rx_v), .rx_char(rx_c), .rx_noise(rx_err[2]),
    .rx_framing(rx_err[1]), .rx_parity(rx_err[0]), .rx_idle_seen(idle),
    .tx_shifter_ready(rdy), .tx_shifter_done(done), .tx_load_q(tx_load_q),
    .tx_word_q(tx_word_q), .nine_bit_mode_q(nine_bit_mode_q),
    .irq_q(irq_q));
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= {24'h000000, d};
    @(posedge sys_clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    q = dat_o[7:0];
    if (n >= 20) mismatches++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk);
  endtask : wb
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk({1'b0, q}, {1'b0, exp});
  endtask : rc
  task automatic tx_send(input logic [7:0] d, input logic [8:0] exp);
    int n;
    int k;
    n = 0;
    k = model.loads;
    wb(1'b1, sci_flags_pkg::OFS_DATA, d);
    while ((model.loads == k || rdy !== 1'b1) && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 50) mismatches++;
    chk(model.last_word_q, exp);
  endtask : tx_send
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    tally_and_finish;
  end
  initial begin
    srst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat_i = 32'h0000_0000;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rc(sci_flags_pkg::OFS_STAT1, 8'hc0);
    rc(8'h18, 8'h00);
    wb(1'b1, sci_flags_pkg::OFS_CTRL1, 8'h40);
    repeat (2) @(posedge sys_clk);
    chk(irq_q, 1'b1);
    wb(1'b1, sci_flags_pkg::OFS_CTRL1, 8'h80);
    rc(sci_flags_pkg::OFS_CTRL1, 8'h80);
    chk(irq_q, 1'b1);
    wb(1'b1, sci_flags_pkg::OFS_CTRL1, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk(irq_q, 1'b0);
    rc(sci_flags_pkg::OFS_STAT1, 8'hc0);
    // Idle flag clear and re-arm
    model.idle_pulse();
    rc(sci_flags_pkg::OFS_STAT1, 8'hd0);
    rc(sci_flags_pkg::OFS_DATA, 8'h00);
    model.idle_pulse();
    rc(sci_flags_pkg::OFS_STAT1, 8'hc0);
    model.send_char(9'h033, 3'h0);
    model.idle_pulse();
    rc(sci_flags_pkg::OFS_STAT1, 8'hf0);
    rc(sci_flags_pkg::OFS_DATA, 8'h33);
    rc(sci_flags_pkg::OFS_STAT1, 8'hc0);
    // Error flags one at a time
    for (int i = 0; i < 3; i++) begin
      model.send_char(9'h040 + 9'(i), 3'h1 << i);
      rc(sci_flags_pkg::OFS_STAT1, 8'he0 | (8'h01 << i));
      rc(sci_flags_pkg::OFS_DATA, 8'h40 + 8'(i));
    end
    // Overrun discards the new character and its errors
    wb(1'b1, sci_flags_pkg::OFS_EVT, 8'h0f);
    model.send_char(9'h0a5, 3'h0);
    @(posedge sys_clk);
    model.send_char(9'h05a, 3'h7);
    rc(sci_flags_pkg::OFS_STAT1, 8'he8);
    rc(sci_flags_pkg::OFS_EVT, 8'h05);
    wb(1'b1, sci_flags_pkg::OFS_MASK, 8'h04);
    repeat (2) @(posedge sys_clk);
    chk(irq_q, 1'b1);
    wb(1'b1, sci_flags_pkg::OFS_EVT, 8'h04);
    repeat (2) @(posedge sys_clk);
    chk(irq_q, 1'b0);
    rc(sci_flags_pkg::OFS_DATA, 8'ha5);
    rc(sci_flags_pkg::OFS_STAT1, 8'hc0);
    // Flag set after the status read is not cleared
    rc(sci_flags_pkg::OFS_STAT1, 8'hc0);
    model.send_char(9'h011, 3'h0);
    rc(sci_flags_pkg::OFS_DATA, 8'h11);
    rc(sci_flags_pkg::OFS_STAT1, 8'he0);
    rc(sci_flags_pkg::OFS_DATA, 8'h11);
    // Nine-bit transmit
    wb(1'b1, sci_flags_pkg::OFS_CTRL1, 8'h10);
    chk(nine_bit_mode_q, 1'b1);
    rc(sci_flags_pkg::OFS_CTRL1, 8'h10);
    wb(1'b1, sci_flags_pkg::OFS_CTRL3, 8'h40);
    tx_send(8'ha5, 9'h1a5);
    tx_send(8'h3c, 9'h13c);
    wb(1'b1, sci_flags_pkg::OFS_CTRL3, 8'h00);
    tx_send(8'h3c, 9'h03c);
    // Nine-bit receive, both read orders
    model.send_char(9'h15a, 3'h0);
    rc(sci_flags_pkg::OFS_STAT1, 8'he0);
    rc(sci_flags_pkg::OFS_DATA, 8'h5a);
    rc(sci_flags_pkg::OFS_STAT1, 8'he0);
    rc(sci_flags_pkg::OFS_CTRL3, 8'h80);
    rc(sci_flags_pkg::OFS_STAT1, 8'hc0);
    model.send_char(9'h0c3, 3'h0);
    rc(sci_flags_pkg::OFS_STAT1, 8'he0);
    rc(sci_flags_pkg::OFS_CTRL3, 8'h00);
    rc(sci_flags_pkg::OFS_DATA, 8'hc3);
    rc(sci_flags_pkg::OFS_STAT1, 8'hc0);
    tally_and_finish;
  end
endmodule : tb
